// ---- testbench/clock_ctrl_monitor.sv ----
// watches link, power-down and control outputs of the register bank
module clock_ctrl_monitor (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // link and power-down
   input wire smb_clk,
   input wire smb_data_in,
   input wire smb_data_out,
   input wire smb_data_oe_n,
   input wire power_down_n,
   // control outputs
   input wire [3:0] freq_code,
   input wire spread_center,
   input wire spread_enable,
   input wire spread_bw_hi,
   input wire spread_bw_lo,
   input wire secondary_cpu_pair_en,
   input wire main_cpu_pair_en,
   input wire cpu_stop_hold,
   input wire cpu_stop_hiz,
   input wire pci_drive_boost,
   input wire [6:0] pci_clock_en,
   input wire selectable_peripheral_clock_48m,
   input wire usb48_clock_en,
   input wire selectable_peripheral_clock_en,
   input wire graphics_skew_hi,
   input wire graphics_skew_lo,
   input wire [2:0] graphics_clock_en
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic clk_q, dat_q;
   logic [3:0] since_stop;
   // cycles since the last stop seen on the raw wires
   always @(posedge clk_sys) begin
      clk_q <= smb_clk;
      dat_q <= smb_data_in;
      if (sys_rst || (clk_q && smb_clk && !dat_q && smb_data_in)) since_stop <= 4'h0;
      else if (since_stop != 4'hF) since_stop <= since_stop + 4'h1;
   end
   property p_apply_on_stop;
      !$stable({freq_code, spread_center, spread_enable, spread_bw_hi, spread_bw_lo,
         secondary_cpu_pair_en, main_cpu_pair_en, pci_drive_boost, pci_clock_en,
         selectable_peripheral_clock_48m, usb48_clock_en, selectable_peripheral_clock_en,
         graphics_skew_hi, graphics_skew_lo, graphics_clock_en}) |-> since_stop < 4'hC;
   endproperty
   property p_drive_clk_low;
      $changed(smb_data_oe_n) |-> !smb_clk;
   endproperty
   property p_data_low;
      smb_data_out == 1'b0;
   endproperty
   property p_stop_cause;
      $rose(cpu_stop_hold || cpu_stop_hiz) |-> !power_down_n && $past(!power_down_n, 2);
   endproperty
   property p_stop_excl;
      !(cpu_stop_hold && cpu_stop_hiz);
   endproperty
   property p_stop_release;
      power_down_n [*8] |-> !cpu_stop_hold && !cpu_stop_hiz;
   endproperty
   property p_rst_cpu;
      disable iff (1'b0) sys_rst |=> spread_enable && !spread_center && spread_bw_hi &&
         spread_bw_lo && secondary_cpu_pair_en && main_cpu_pair_en && !cpu_stop_hold &&
         !cpu_stop_hiz;
   endproperty
   property p_rst_periph;
      disable iff (1'b0) sys_rst |=> pci_clock_en == 7'h7F && !pci_drive_boost &&
         !selectable_peripheral_clock_48m && usb48_clock_en && selectable_peripheral_clock_en
         && !graphics_skew_hi && !graphics_skew_lo && graphics_clock_en == 3'h7;
   endproperty
   a_apply_on_stop: assert property (p_apply_on_stop) else $error("output moved without stop");
   a_drive_clk_low: assert property (p_drive_clk_low) else $error("data moved, clock high");
   a_data_low: assert property (p_data_low) else $error("data out not low");
   a_stop_cause: assert property (p_stop_cause) else $error("stop without power-down");
   a_stop_excl: assert property (p_stop_excl) else $error("both stop states");
   a_stop_release: assert property (p_stop_release) else $error("stop held while up");
   a_rst_cpu: assert property (p_rst_cpu) else $error("cpu reset value");
   a_rst_periph: assert property (p_rst_periph) else $error("periph reset value");
   c_hold: cover property ($rose(cpu_stop_hold));
   c_hiz: cover property ($rose(cpu_stop_hiz));
   c_ack: cover property ($fell(smb_data_oe_n));
   c_freq: cover property ($changed(freq_code));
endmodule

// ---- testbench/clock_gen_serial_control_regs_tb.sv ----
// register bank driven by the host model, checked against a byte model
module clock_gen_serial_control_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'b0, sys_rst = 1'b1, power_down_n = 1'b1;
   logic [3:0] freq_code_strap = 4'h0;
   logic memory_rate_strap = 1'b0, processor_mode_strap = 1'b1;
   logic current_multiplier_strap = 1'b0;
   wire smb_clk, smb_data_in, smb_data_out, smb_data_oe_n;
   wire [3:0] freq_code;
   wire [6:0] pci_clock_en;
   wire [2:0] graphics_clock_en;
   wire spread_center, spread_enable, spread_bw_hi, spread_bw_lo, secondary_cpu_pair_en;
   wire main_cpu_pair_en, cpu_stop_hold, cpu_stop_hiz, pci_drive_boost, usb48_clock_en;
   wire selectable_peripheral_clock_48m, selectable_peripheral_clock_en;
   wire graphics_skew_hi, graphics_skew_lo;
   int mismatches = 0, checked = 0, seed = 32'h177f;
   logic sw_sel = 1'b0;
   logic [3:0] sw_code = 4'h0;
   logic [7:0] m1, m2, m3, r;
   // expected code and the observed control bytes
   wire [3:0] exp_code = sw_sel ? sw_code : freq_code_strap;
   wire [7:0] ob1 = {spread_center, spread_enable, spread_bw_hi, spread_bw_lo,
      secondary_cpu_pair_en, main_cpu_pair_en, 2'b00};
   wire [7:0] ob3 = {selectable_peripheral_clock_48m, usb48_clock_en,
      selectable_peripheral_clock_en, graphics_skew_hi, graphics_skew_lo, graphics_clock_en};
   clock_gen_serial_control_regs i_dut (.*);
   smbus_host_model i_host (.*);
   // system clock
   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // value a read of each offset must return
   function automatic logic [7:0] exp_rd(input int o);
      case (o)
         0: return {1'b0, exp_code[2:0], sw_sel, memory_rate_strap, exp_code[3],
            processor_mode_strap};
         1: return {m1[7:1], current_multiplier_strap};
         2: return m2;
         3: return m3;
         default: return 8'h00;
      endcase
   endfunction
   // new straps, reset, and the byte model back to power-up values
   task do_reset(input logic proc);
      r = $random(seed);
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      freq_code_strap <= r[3:0];
      memory_rate_strap <= r[4];
      current_multiplier_strap <= r[5];
      processor_mode_strap <= proc;
      repeat (6) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (10) @(posedge clk_sys);
      sw_sel = 1'b0;
      m1 = 8'h7E;
      m2 = 8'h7F;
      m3 = 8'h67;
   endtask
   // host write, then the byte model follows when the write is expected to be accepted
   task wr_m(input logic [7:0] cmd, input logic [7:0] d, input logic exp_ok);
      logic ok;
      i_host.wr(cmd, d, ok);
      chk("write ack", {7'h0, ok}, {7'h0, exp_ok});
      if (exp_ok) begin
         case (cmd[6:0])
            7'h0: begin
               sw_sel = d[3];
               if (d[3]) sw_code = {d[1], d[6:4]};
            end
            7'h1: m1[7:1] = d[7:1];
            7'h2: m2 = d;
            7'h3: m3 = d;
            default: ;
         endcase
      end
   endtask
   // read back offsets 0 to 4 and compare the control outputs
   task check_all;
      logic [7:0] d;
      logic ok;
      for (int o = 0; o < 5; o++) begin
         i_host.rd(8'h80 | 8'(o), d, ok);
         chk("read ack", {7'h0, ok}, 8'h01);
         chk("read byte", d, exp_rd(o));
      end
      chk("freq code", {4'h0, freq_code}, {4'h0, exp_code});
      chk("cpu byte", ob1, {m1[7:2], 2'b00});
      chk("pci byte", {pci_drive_boost, pci_clock_en}, m2);
      chk("gfx byte", ob3, m3);
   endtask
   // drive power-down and compare the cpu stop state
   task pd_check(input logic pd, input logic [1:0] e);
      @(posedge clk_sys);
      power_down_n <= pd;
      repeat (10) @(posedge clk_sys);
      for (int i = 0; i < 20 && {cpu_stop_hold, cpu_stop_hiz} !== e; i++) @(posedge clk_sys);
      chk("stop state", {6'h0, cpu_stop_hold, cpu_stop_hiz}, {6'h0, e});
   endtask
   // main sequence
   initial begin
      do_reset(1'b1);
      check_all();
      wr_m(8'h80, 8'hFA, 1'b1);
      check_all();
      wr_m(8'h80, 8'h75, 1'b1);
      check_all();
      wr_m(8'h02, 8'h00, 1'b0);
      // a frame for another address must be left alone
      i_host.dev = ~i_host.DEV_ADDR;
      wr_m(8'h82, 8'h00, 1'b0);
      i_host.dev = i_host.DEV_ADDR;
      wr_m(8'h84, 8'h55, 1'b1);
      wr_m(8'h83, 8'h00, 1'b1);
      check_all();
      for (int i = 0; i < 10; i++) begin
         r = $random(seed);
         if (i == 7) i_host.q = 32;
         wr_m(8'h80 | {6'h0, r[1:0]}, 8'($random(seed)), 1'b1);
         check_all();
      end
      i_host.q = 16;
      wr_m(8'h81, 8'h7C, 1'b1);
      pd_check(1'b0, 2'b10);
      wr_m(8'h81, 8'h7E, 1'b1);
      pd_check(1'b0, 2'b01);
      pd_check(1'b1, 2'b00);
      do_reset(1'b0);
      check_all();
      pd_check(1'b0, 2'b00);
      pd_check(1'b1, 2'b00);
      wrap_up();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk_sys);
      mismatches++;
      wrap_up();
   end
endmodule
bind clock_gen_serial_control_regs clock_ctrl_monitor i_mon (.*);

// ---- testbench/smbus_host_model.sv ----
// serial host that owns the link clock and shares the data wire
module smbus_host_model #(
   parameter [6:0] DEV_ADDR = 7'h69
) (
   // link wires
   output logic smb_clk,
   output wire smb_data_in,
   input wire smb_data_oe_n
);
   timeunit 1ns;
   timeprecision 100ps;
   int q = 16;
   logic sda_h = 1'b1;
   // address put on the wire; the bench may aim it elsewhere
   logic [6:0] dev = DEV_ADDR;
   // wired-and of both parties; a released line is pulled up
   wire line = sda_h & smb_data_oe_n;
   assign smb_data_in = line;
   // clock idles high between frames
   initial begin
      smb_clk = 1'b1;
   end
   // one bit: data moves while the clock is low, sampled at the rise
   task automatic bitx(input logic b, output logic r);
      #q sda_h = b;
      #q smb_clk = 1'b1;
      r = line;
      #(2 * q) smb_clk = 1'b0;
   endtask
   // start or repeated start
   task automatic st;
      #q sda_h = 1'b1;
      #q smb_clk = 1'b1;
      #q sda_h = 1'b0;
      #q smb_clk = 1'b0;
   endtask
   // stop, then the data line is left released
   task automatic sp;
      #q sda_h = 1'b0;
      #q smb_clk = 1'b1;
      #q sda_h = 1'b1;
      #q;
   endtask
   // eight bits out and in, then the ninth bit; ack is the line low there
   task automatic xb(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
      bitx(1'b1, a);
      ack = !a;
   endtask
   // byte write: address, command, data, stop
   task automatic wr(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2;
      st();
      xb({dev, 1'b0}, rx, a0);
      xb(cmd, rx, a1);
      xb(d, rx, a2);
      sp();
      ok = a0 & a1 & a2;
   endtask
   // byte read: command, repeated start, data with a closing not-ack
   task automatic rd(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
      logic [7:0] rx;
      logic a0, a1, a2, an;
      st();
      xb({dev, 1'b0}, rx, a0);
      xb(cmd, rx, a1);
      st();
      xb({dev, 1'b1}, rx, a2);
      xb(8'hFF, d, an);
      sp();
      ok = a0 & a1 & a2;
   endtask
endmodule

// ---- verilog/bit_sync.v ----
// two flip-flop synchroniser for levels from outside the clock domain
module bit_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;

   // first stage feeds only the second stage
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule

// ---- verilog/clock_ctrl_defs.vh ----
`ifndef CLOCK_CTRL_DEFS_VH
`define CLOCK_CTRL_DEFS_VH

// register byte offsets
`define OFF_FREQ_SELECT 7'h00
`define OFF_CPU_CTRL 7'h01
`define OFF_PCI_CTRL 7'h02
`define OFF_GFX_PERIPH_CTRL 7'h03

// frequency select byte field positions
`define FS_RESERVED_BIT 7
`define FS_CODE2_BIT 6
`define FS_CODE1_BIT 5
`define FS_CODE0_BIT 4
`define FS_SW_SELECT_BIT 3
`define FS_MEMORY_RATE_BIT 2
`define FS_CODE3_BIT 1
`define FS_PROC_MODE_BIT 0

// cpu control byte field positions
`define CPU_SPREAD_CENTER_BIT 7
`define CPU_SPREAD_ENABLE_BIT 6
`define CPU_SPREAD_BW_HI_BIT 5
`define CPU_SPREAD_BW_LO_BIT 4
`define CPU_SECONDARY_EN_BIT 3
`define CPU_MAIN_EN_BIT 2
`define CPU_STOP_HIZ_BIT 1
`define CPU_MULT_STRAP_BIT 0

// pci control byte field positions
`define PCI_DRIVE_BOOST_BIT 7
`define PCI_FREE_EN_BIT 6

// graphics and peripheral byte field positions
`define GFX_SEL48_BIT 7
`define GFX_USB48_EN_BIT 6
`define GFX_SEL_EN_BIT 5
`define GFX_SKEW_HI_BIT 4
`define GFX_SKEW_LO_BIT 3

// reset values of the writable parts
`define RST_SW_SELECT 1'b0
`define RST_CPU_CTRL_HI 7'h3F
`define RST_PCI_CTRL 8'h7F
`define RST_GFX_PERIPH_CTRL 8'h67

// command code marking a single byte access
`define CMD_BYTE_OP_BIT 7

// synchroniser depth before a strap is valid after reset release
`define STRAP_CAPTURE_CYCLE 2'h2

`endif

// ---- verilog/clock_gen_serial_control_regs.v ----
`include "clock_ctrl_defs.vh"

// Contract
// RL1 - bit 3 of byte 0 set lets the host write the frequency code
// RL2 - bit 3 clear makes frequency bits read-only, showing strapped values
// RL3 - frequency code bits 2..0 from byte 0 bits 6..4, bit 3 from bit 1
// RL4 - byte 0 bit 2 reads the strapped memory rate mode, unwritable
// RL5 - byte 0 bit 0 reads the strapped processor mode, unwritable
// RL6 - byte 1 bit 7 picks down or center spread, resets to zero
// RL7 - byte 1 bit 6 enables spread modulation, resets to one
// RL8 - byte 1 bits 5:4 form spread bandwidth code, both reset to one
// RL9 - per-output enable bits keep clock running at one, force low at zero
// RL10 - byte 1 bit 2 enables the main cpu pair, resets to one
// RL11 - byte 1 bit 1 picks cpu stop state in power-down, primary mode only
// RL12 - byte 1 bit 0 reads the strapped current multiplier, unwritable
// RL13 - byte 2 bit 7 boosts pci drive strength, resets to zero
// RL14 - byte 2 bits 6..0 enable free-running pci and pci clocks six..one
// RL15 - byte 3 bit 7 selects 24 or 48 MHz peripheral output, resets zero
// RL16 - byte 3 bits 4:3 form graphics skew code, both reset to zero
// RL17 - byte 3 bits 6,5,2,1,0 enable 48 MHz, selectable, graphics two..zero
// RL18 - command code with top bit set gives low seven bits as byte offset
// RL19 - reserved bit reads zero; new values apply once the host write ends
module clock_gen_serial_control_regs #(
   parameter [6:0] SLAVE_ADDR = 7'h69
) (
   // system clock and reset
   input wire clk_sys,
   input wire sys_rst,
   // serial link
   input wire smb_clk,
   input wire smb_data_in,
   output wire smb_data_out,
   output wire smb_data_oe_n,
   // strapping and power-down pins
   input wire [3:0] freq_code_strap,
   input wire memory_rate_strap,
   input wire processor_mode_strap,
   input wire current_multiplier_strap,
   input wire power_down_n,
   // frequency and spread controls
   output wire [3:0] freq_code,
   output wire spread_center,
   output wire spread_enable,
   output wire spread_bw_hi,
   output wire spread_bw_lo,
   // cpu clock controls
   output wire secondary_cpu_pair_en,
   output wire main_cpu_pair_en,
   output wire cpu_stop_hold,
   output wire cpu_stop_hiz,
   // pci clock controls
   output wire pci_drive_boost,
   output wire [6:0] pci_clock_en,
   // graphics and peripheral controls
   output wire selectable_peripheral_clock_48m,
   output wire usb48_clock_en,
   output wire selectable_peripheral_clock_en,
   output wire graphics_skew_hi,
   output wire graphics_skew_lo,
   output wire [2:0] graphics_clock_en
);

   localparam [4:0] ST_IDLE = 5'h01;
   localparam [4:0] ST_RECV = 5'h02;
   localparam [4:0] ST_ACK = 5'h04;
   localparam [4:0] ST_SEND = 5'h08;
   localparam [4:0] ST_RACK = 5'h10;

   wire [1:0] link_s;
   wire [7:0] pins_s;
   wire scl_s;
   wire sda_s;
   wire pd_n_s;

   reg scl_prev_q;
   reg sda_prev_q;
   reg [4:0] state_q;
   reg [3:0] bit_cnt_q;
   reg [1:0] byte_idx_q;
   reg [7:0] shift_q;
   reg rw_q;
   reg [6:0] off_q;
   reg [7:0] wr_data_q;
   reg wr_pend_q;
   reg commit_q;
   reg sda_drive_q;
   reg sda_out_q;
   reg nack_q;

   reg [1:0] strap_cnt_q;
   reg [3:0] strap_freq_q;
   reg mem_strap_q;
   reg proc_strap_q;
   reg mult_strap_q;
   reg sw_sel_q;
   reg [3:0] sw_freq_q;
   reg [7:1] cpu_ctrl_q;
   reg [7:0] pci_ctrl_q;
   reg [7:0] gfx_ctrl_q;
   reg [3:0] freq_code_q;
   reg cpu_stop_hold_q;
   reg cpu_stop_hiz_q;

   reg [7:0] rd_data;
   reg [3:0] freq_rd;

   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;

   // synchronise the link pins
   bit_sync #(
      .WIDTH(2),
      .INIT(2'h3)
   ) u_link_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({smb_clk, smb_data_in}),
      .sync_out(link_s)
   );

   // synchronise straps and power-down
   bit_sync #(
      .WIDTH(8),
      .INIT(8'h80)
   ) u_pin_sync (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .async_in({power_down_n, current_multiplier_strap, processor_mode_strap,
                 memory_rate_strap, freq_code_strap}),
      .sync_out(pins_s)
   );

   assign scl_s = link_s[1];
   assign sda_s = link_s[0];
   assign pd_n_s = pins_s[7];

   // link edge and condition detection on synchronised levels
   assign scl_rise = scl_s & ~scl_prev_q;
   assign scl_fall = ~scl_s & scl_prev_q;
   assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
   assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

   // read data for the addressed byte
   always @* begin
      freq_rd = sw_sel_q ? sw_freq_q : strap_freq_q; // RL2
      rd_data = 8'h00;
      case (off_q)
         `OFF_FREQ_SELECT: begin
            rd_data[`FS_RESERVED_BIT] = 1'b0; // RL19
            rd_data[`FS_CODE2_BIT] = freq_rd[2]; // RL3
            rd_data[`FS_CODE1_BIT] = freq_rd[1];
            rd_data[`FS_CODE0_BIT] = freq_rd[0];
            rd_data[`FS_SW_SELECT_BIT] = sw_sel_q;
            rd_data[`FS_MEMORY_RATE_BIT] = mem_strap_q; // RL4
            rd_data[`FS_CODE3_BIT] = freq_rd[3];
            rd_data[`FS_PROC_MODE_BIT] = proc_strap_q; // RL5
         end
         `OFF_CPU_CTRL: begin
            rd_data = {cpu_ctrl_q, mult_strap_q}; // RL12
         end
         `OFF_PCI_CTRL: begin
            rd_data = pci_ctrl_q;
         end
         `OFF_GFX_PERIPH_CTRL: begin
            rd_data = gfx_ctrl_q;
         end
         default: begin
            rd_data = 8'h00;
         end
      endcase
   end

   // serial slave: byte write and byte read sequences
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
         state_q <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         byte_idx_q <= 2'h0;
         shift_q <= 8'h00;
         rw_q <= 1'b0;
         off_q <= 7'h00;
         wr_data_q <= 8'h00;
         wr_pend_q <= 1'b0;
         commit_q <= 1'b0;
         sda_drive_q <= 1'b0;
         sda_out_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         scl_prev_q <= scl_s;
         sda_prev_q <= sda_s;
         commit_q <= 1'b0;
         if (start_det) begin
            state_q <= ST_RECV;
            bit_cnt_q <= 4'h0;
            byte_idx_q <= 2'h0;
            sda_drive_q <= 1'b0;
            wr_pend_q <= 1'b0;
         end else if (stop_det) begin
            // a staged write takes effect only once the transfer ends
            state_q <= ST_IDLE;
            sda_drive_q <= 1'b0;
            commit_q <= wr_pend_q; // RL19
            wr_pend_q <= 1'b0;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  sda_drive_q <= 1'b0;
               end
               ST_RECV: begin
                  if (scl_rise) begin
                     shift_q <= {shift_q[6:0], sda_s};
                     bit_cnt_q <= bit_cnt_q + 4'h1;
                  end else if (scl_fall && bit_cnt_q == 4'h8) begin
                     bit_cnt_q <= 4'h0;
                     case (byte_idx_q)
                        2'h0: begin
                           if (shift_q[7:1] == SLAVE_ADDR) begin
                              rw_q <= shift_q[0];
                              byte_idx_q <= 2'h1;
                              sda_drive_q <= 1'b1;
                              state_q <= ST_ACK;
                           end else begin
                              state_q <= ST_IDLE;
                           end
                        end
                        2'h1: begin
                           if (shift_q[`CMD_BYTE_OP_BIT]) begin
                              off_q <= shift_q[6:0]; // RL18
                              byte_idx_q <= 2'h2;
                              sda_drive_q <= 1'b1;
                              state_q <= ST_ACK;
                           end else begin
                              state_q <= ST_IDLE;
                           end
                        end
                        default: begin
                           wr_data_q <= shift_q;
                           wr_pend_q <= 1'b1;
                           sda_drive_q <= 1'b1;
                           state_q <= ST_ACK;
                        end
                     endcase
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rw_q) begin
                        shift_q <= rd_data;
                        sda_drive_q <= ~rd_data[7];
                        bit_cnt_q <= 4'h1;
                        state_q <= ST_SEND;
                     end else begin
                        sda_drive_q <= 1'b0;
                        state_q <= ST_RECV;
                     end
                  end
               end
               ST_SEND: begin
                  if (scl_fall) begin
                     if (bit_cnt_q == 4'h8) begin
                        sda_drive_q <= 1'b0;
                        state_q <= ST_RACK;
                     end else begin
                        sda_drive_q <= ~shift_q[6];
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_s;
                  end else if (scl_fall) begin
                     if (nack_q) begin
                        state_q <= ST_IDLE;
                     end else begin
                        shift_q <= rd_data;
                        sda_drive_q <= ~rd_data[7];
                        bit_cnt_q <= 4'h1;
                        state_q <= ST_SEND;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
                  sda_drive_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // register bank: strap capture after release, committed host writes
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         strap_cnt_q <= 2'h0;
         strap_freq_q <= 4'h0;
         mem_strap_q <= 1'b0;
         proc_strap_q <= 1'b0;
         mult_strap_q <= 1'b0;
         sw_sel_q <= `RST_SW_SELECT;
         sw_freq_q <= 4'h0;
         cpu_ctrl_q <= `RST_CPU_CTRL_HI; // RL6 RL7 RL8 RL10
         pci_ctrl_q <= `RST_PCI_CTRL; // RL13
         gfx_ctrl_q <= `RST_GFX_PERIPH_CTRL; // RL15 RL16
      end else begin
         if (strap_cnt_q != 2'h3) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
         end
         if (strap_cnt_q == `STRAP_CAPTURE_CYCLE) begin
            strap_freq_q <= pins_s[3:0];
            mem_strap_q <= pins_s[4];
            proc_strap_q <= pins_s[5];
            mult_strap_q <= pins_s[6];
            sw_freq_q <= pins_s[3:0];
         end else if (commit_q) begin
            case (off_q)
               `OFF_FREQ_SELECT: begin
                  sw_sel_q <= wr_data_q[`FS_SW_SELECT_BIT];
                  if (wr_data_q[`FS_SW_SELECT_BIT]) begin
                     sw_freq_q <= {wr_data_q[`FS_CODE3_BIT], wr_data_q[`FS_CODE2_BIT],
                                   wr_data_q[`FS_CODE1_BIT], wr_data_q[`FS_CODE0_BIT]}; // RL1 RL3
                  end
               end
               `OFF_CPU_CTRL: begin
                  cpu_ctrl_q <= wr_data_q[7:1]; // RL12
               end
               `OFF_PCI_CTRL: begin
                  pci_ctrl_q <= wr_data_q; // RL14
               end
               `OFF_GFX_PERIPH_CTRL: begin
                  gfx_ctrl_q <= wr_data_q; // RL17
               end
               default: begin
                  sw_sel_q <= sw_sel_q;
               end
            endcase
         end
      end
   end

   // derived outputs: frequency code and cpu stop state in power-down
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         freq_code_q <= 4'h0;
         cpu_stop_hold_q <= 1'b0;
         cpu_stop_hiz_q <= 1'b0;
      end else begin
         freq_code_q <= sw_sel_q ? sw_freq_q : strap_freq_q; // RL1 RL2
         cpu_stop_hold_q <= proc_strap_q & ~pd_n_s & ~cpu_ctrl_q[`CPU_STOP_HIZ_BIT]; // RL11
         cpu_stop_hiz_q <= proc_strap_q & ~pd_n_s & cpu_ctrl_q[`CPU_STOP_HIZ_BIT]; // RL11
      end
   end

   // open-drain data pin, enable low while pulling low
   assign smb_data_out = sda_out_q;
   assign smb_data_oe_n = ~sda_drive_q;

   // control outputs straight from the bank flops, frequency code and cpu stop state from the derived-output flops
   assign freq_code = freq_code_q;
   assign spread_center = cpu_ctrl_q[`CPU_SPREAD_CENTER_BIT]; // RL6
   assign spread_enable = cpu_ctrl_q[`CPU_SPREAD_ENABLE_BIT]; // RL7
   assign spread_bw_hi = cpu_ctrl_q[`CPU_SPREAD_BW_HI_BIT]; // RL8
   assign spread_bw_lo = cpu_ctrl_q[`CPU_SPREAD_BW_LO_BIT]; // RL8
   assign secondary_cpu_pair_en = cpu_ctrl_q[`CPU_SECONDARY_EN_BIT]; // RL9
   assign main_cpu_pair_en = cpu_ctrl_q[`CPU_MAIN_EN_BIT]; // RL10
   assign cpu_stop_hold = cpu_stop_hold_q;
   assign cpu_stop_hiz = cpu_stop_hiz_q;
   assign pci_drive_boost = pci_ctrl_q[`PCI_DRIVE_BOOST_BIT]; // RL13
   assign pci_clock_en = pci_ctrl_q[`PCI_FREE_EN_BIT:0]; // RL9 RL14
   assign selectable_peripheral_clock_48m = gfx_ctrl_q[`GFX_SEL48_BIT]; // RL15
   assign usb48_clock_en = gfx_ctrl_q[`GFX_USB48_EN_BIT]; // RL9 RL17
   assign selectable_peripheral_clock_en = gfx_ctrl_q[`GFX_SEL_EN_BIT]; // RL17
   assign graphics_skew_hi = gfx_ctrl_q[`GFX_SKEW_HI_BIT]; // RL16
   assign graphics_skew_lo = gfx_ctrl_q[`GFX_SKEW_LO_BIT]; // RL16
   assign graphics_clock_en = gfx_ctrl_q[2:0]; // RL17

endmodule
